// >>> cpu_core_regs.vh
// Constants for the CPU register and flag core
// Overview of operation
// (RULE_01) One 8-bit accumulator for ALU operands/results
// (RULE_02) 16-bit index pointer from upper and lower bytes
// (RULE_03) Reset loads stack pointer with 00FF
// (RULE_04) Reset-stack instruction sets low byte FF
// (RULE_05) Stack pointer decrements on push, increments pull
// (RULE_06) Stack-relative address is stack pointer plus offset
// (RULE_07) Program counter increments, or loads on jumps
// (RULE_08) Reset fetches vector from FFFE and FFFF
// (RULE_09) Flags hold mask, five flags; bits 6,5 one
// (RULE_10) Overflow flag tracks two's complement overflow
// (RULE_11) Half-carry from bit 3 to 4 on adds
// (RULE_12) Mask blocks interrupts; set after stacking, before vector
// (RULE_13) Interrupt entry does not stack upper index byte
// (RULE_14) Pending interrupts served highest priority first
// (RULE_15) Return restores mask; reset sets it
// (RULE_16) Negative flag equals result bit 7
// (RULE_17) Zero flag set when result is 00
// (RULE_18) Carry from bit 7 or borrow; shifts too
// (RULE_19) Wait clears mask and stops CPU clock
// (RULE_20) Stop clears mask; restart after stabilization delay
// (RULE_21) Break loads software interrupt opcode and vector
// (RULE_22) Break starts after instruction; return needs deassert
// (RULE_23) Unaffected flags keep their previous values
`ifndef CPU_CORE_REGS_VH
`define CPU_CORE_REGS_VH

// AXI4-Lite byte offsets
`define OFS_ACC 8'h00
`define OFS_IDX 8'h04
`define OFS_SP 8'h08
`define OFS_PC 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_STATUS 8'h14
`define OFS_CTRL 8'h18
`define OFS_VEC 8'h1C

// Reset values and vector addresses
`define SP_RESET 16'h00FF
`define SP_LOW_RESET 8'hFF
`define VEC_RESET 16'hFFFE
`define VEC_BREAK 16'hFFFC
`define VEC_BREAK_MON 16'hFEFC
`define FLAGS_FIXED 8'h60
`define SWI_OPCODE 8'h83

// Flag bit positions
`define FLG_V 7
`define FLG_H 4
`define FLG_I 3
`define FLG_N 2
`define FLG_Z 1
`define FLG_C 0

// Operation codes from the sequencer
`define OP_NONE 4'h0
`define OP_ADD 4'h1
`define OP_ADC 4'h2
`define OP_SUB 4'h3
`define OP_AND 4'h4
`define OP_OR 4'h5
`define OP_EOR 4'h6
`define OP_LDA 4'h7
`define OP_ASL 4'h8
`define OP_LSR 4'h9
`define OP_ROR 4'hA
`define OP_BITC 4'hB

// Oscillator stabilization delay, in cycles of core_clk
`define STAB_NS 256000
`define STAB_CYCLES ((`STAB_NS + 7) / 8)

`endif

// >>> cpu_core.v
// CPU programmer-visible registers, flag logic and AXI4-Lite access port
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`include "cpu_core_regs.vh"

module cpu_core #(
  parameter [31:0] STAB_COUNT = `STAB_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // AXI4-Lite write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Sequencer micro-operations
  input wire [3:0] alu_op,
  input wire [7:0] alu_operand,
  input wire pc_inc,
  input wire pc_load,
  input wire [15:0] pc_target,
  input wire sp_push,
  input wire sp_pull,
  input wire reset_stack_instr,
  input wire clear_mask_instr,
  input wire set_mask_instr,
  input wire mask_restore,
  input wire [7:0] flags_pulled,
  input wire irq_stacked,
  input wire wait_instr,
  input wire stop_instr,
  input wire [7:0] irq_pending,
  input wire instr_last_cycle,
  input wire break_request,
  input wire break_match,
  input wire monitor_mode,
  input wire vector_load,
  input wire [15:0] vector_data,
  input wire ext_irq_pin,
  input wire [15:0] sp_offset,
  // Core results
  output reg [15:0] stack_address,
  output reg irq_accept,
  output reg [2:0] irq_number,
  output reg [15:0] vector_address,
  output reg vector_fetch,
  output reg [7:0] instr_reg,
  output reg cpu_clk_en,
  output reg break_active
);

  // Architectural registers
  reg [7:0] acc_r;
  reg [15:0] idx_r;
  reg [15:0] sp_r;
  reg [15:0] pc_r;
  reg [5:0] flg_r; // V H I N Z C packed
  reg [7:0] flags_view;

  // Low power and break state
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_STOP = 2'd2;
  localparam [1:0] ST_STAB = 2'd3;
  reg [1:0] pwr_r;
  reg [31:0] stab_r;
  reg brk_pend_r;
  reg boot_r;
  reg ext_s1_r;
  reg ext_s2_r;
  reg ctrl_go_r;

  // Map the packed flags into the 8-bit view
  always @* begin
    flags_view = `FLAGS_FIXED; // RULE_09
    flags_view[`FLG_V] = flg_r[5];
    flags_view[`FLG_H] = flg_r[4];
    flags_view[`FLG_I] = flg_r[3];
    flags_view[`FLG_N] = flg_r[2];
    flags_view[`FLG_Z] = flg_r[1];
    flags_view[`FLG_C] = flg_r[0];
  end

  // Lowest set bit wins: index 0 is the highest priority
  function [3:0] pick_irq;
    input [7:0] req;
    integer k;
    begin
      pick_irq = 4'h8;
      for (k = 7; k >= 0; k = k - 1) begin
        if (req[k]) begin
          pick_irq = k[3:0];
        end
      end
    end
  endfunction

  // ALU with flag results
  reg [8:0] sum;
  reg [4:0] low_sum;
  reg [7:0] res;
  reg [5:0] flg_nxt;
  reg do_flags;
  always @* begin
    sum = 9'h000;
    low_sum = 5'h00;
    res = acc_r;
    flg_nxt = flg_r; // RULE_23
    do_flags = 1'b1;
    case (alu_op)
      `OP_ADD, `OP_ADC: begin
        sum = {1'b0, acc_r} + {1'b0, alu_operand} +
              {8'h00, (alu_op == `OP_ADC) & flg_r[0]};
        low_sum = {1'b0, acc_r[3:0]} + {1'b0, alu_operand[3:0]} +
                  {4'h0, (alu_op == `OP_ADC) & flg_r[0]};
        res = sum[7:0];
        flg_nxt[4] = low_sum[4]; // RULE_11
        flg_nxt[0] = sum[8]; // RULE_18
        flg_nxt[5] = (acc_r[7] == alu_operand[7]) && (res[7] != acc_r[7]); // RULE_10
      end
      `OP_SUB: begin
        sum = {1'b0, acc_r} - {1'b0, alu_operand};
        res = sum[7:0];
        flg_nxt[0] = sum[8]; // RULE_18
        flg_nxt[5] = (acc_r[7] != alu_operand[7]) && (res[7] != acc_r[7]); // RULE_10
      end
      `OP_AND, `OP_OR, `OP_EOR, `OP_LDA: begin
        if (alu_op == `OP_AND) begin
          res = acc_r & alu_operand;
        end else if (alu_op == `OP_OR) begin
          res = acc_r | alu_operand;
        end else if (alu_op == `OP_EOR) begin
          res = acc_r ^ alu_operand;
        end else begin
          res = alu_operand;
        end
        flg_nxt[5] = 1'b0;
      end
      `OP_ASL: begin
        res = {acc_r[6:0], 1'b0};
        flg_nxt[0] = acc_r[7]; // RULE_18
        flg_nxt[5] = acc_r[7] ^ acc_r[6];
      end
      `OP_LSR, `OP_ROR: begin
        res = {(alu_op == `OP_ROR) & flg_r[0], acc_r[7:1]};
        flg_nxt[0] = acc_r[0]; // RULE_18
        flg_nxt[5] = res[7] ^ acc_r[0];
      end
      `OP_BITC: begin
        // Bit test: carry takes the tested bit, accumulator untouched
        do_flags = 1'b0;
        flg_nxt[0] = alu_operand[0]; // RULE_18
      end
      default: begin
        do_flags = 1'b0;
      end
    endcase
    if (do_flags) begin
      flg_nxt[2] = res[7]; // RULE_16
      flg_nxt[1] = (res == 8'h00); // RULE_17
    end
  end

  // AXI4-Lite slave: accept address and data in either order
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] aw_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_fire = aw_got_r && w_got_r;

  // Byte-lane merge of a write word into a register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // Read data mux
  reg [31:0] rd_word;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFS_ACC: rd_word = {24'h000000, acc_r};
      `OFS_IDX: rd_word = {16'h0000, idx_r};
      `OFS_SP: rd_word = {16'h0000, sp_r};
      `OFS_PC: rd_word = {16'h0000, pc_r};
      `OFS_FLAGS: rd_word = {24'h000000, flags_view};
      `OFS_STATUS: rd_word = {26'h0000000, boot_r, break_active, brk_pend_r, cpu_clk_en,
                              pwr_r};
      `OFS_CTRL: rd_word = {31'h00000000, ctrl_go_r};
      `OFS_VEC: rd_word = {24'h000000, instr_reg};
      default: begin
        rd_word = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  wire [3:0] irq_sel = pick_irq(irq_pending);
  wire irq_ok = !flg_r[3] && (irq_sel != 4'h8); // RULE_12
  wire run = (pwr_r == ST_RUN) && ctrl_go_r;

  // Stack-relative operand address
  always @(posedge core_clk) begin
    stack_address <= sp_r + sp_offset; // RULE_06
  end

  // Main sequential process
  always @(posedge core_clk) begin
    if (rst) begin
      acc_r <= 8'h00;
      idx_r <= 16'h0000;
      sp_r <= `SP_RESET; // RULE_03
      pc_r <= 16'h0000;
      flg_r <= 6'h08; // RULE_15
      pwr_r <= ST_RUN;
      stab_r <= 32'h00000000;
      brk_pend_r <= 1'b0;
      break_active <= 1'b0;
      boot_r <= 1'b1;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ctrl_go_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
      irq_accept <= 1'b0;
      irq_number <= 3'd0;
      vector_address <= `VEC_RESET; // RULE_08
      vector_fetch <= 1'b1;
      instr_reg <= 8'h00;
      cpu_clk_en <= 1'b1;
    end else begin
      // External wake pin, two-stage synchroniser
      ext_s1_r <= ext_irq_pin;
      ext_s2_r <= ext_s1_r;
      irq_accept <= 1'b0;
      vector_fetch <= 1'b0;
      // Reset vector: high byte then low byte arrive as one word
      if (boot_r && vector_load) begin
        pc_r <= vector_data; // RULE_08
        boot_r <= 1'b0;
      end else if (run && !boot_r) begin
        if (alu_op != `OP_NONE && alu_op != `OP_BITC) begin
          acc_r <= res; // RULE_01
        end
        flg_r <= flg_nxt;
        if (pc_load) begin
          pc_r <= pc_target; // RULE_07
        end else if (pc_inc) begin
          pc_r <= pc_r + 16'h0001; // RULE_07
        end
        if (reset_stack_instr) begin
          sp_r <= {sp_r[15:8], `SP_LOW_RESET}; // RULE_04
        end else if (sp_push) begin
          sp_r <= sp_r - 16'h0001; // RULE_05
        end else if (sp_pull) begin
          sp_r <= sp_r + 16'h0001; // RULE_05
        end
        // Flag writes from mask instructions and return
        if (mask_restore) begin
          flg_r <= {flags_pulled[`FLG_V], flags_pulled[`FLG_H], flags_pulled[`FLG_I],
                    flags_pulled[`FLG_N], flags_pulled[`FLG_Z], flags_pulled[`FLG_C]}; // RULE_15
          if (break_active && !break_request) begin
            break_active <= 1'b0; // RULE_22
          end
        end else if (clear_mask_instr) begin
          flg_r[3] <= 1'b0; // RULE_15
        end else if (set_mask_instr) begin
          flg_r[3] <= 1'b1;
        end
        // Break takes priority over maskable requests
        if (break_match) begin
          brk_pend_r <= 1'b1;
        end
        if ((brk_pend_r || break_match) && instr_last_cycle && !break_active) begin
          instr_reg <= `SWI_OPCODE; // RULE_21
          vector_address <= monitor_mode ? `VEC_BREAK_MON : `VEC_BREAK; // RULE_21
          vector_fetch <= 1'b1;
          break_active <= 1'b1; // RULE_22
          brk_pend_r <= 1'b0;
        end else if (irq_stacked && irq_ok) begin
          // Only PC, X, A and flags were stacked; upper index untouched
          flg_r[3] <= 1'b1; // RULE_12 RULE_13
          irq_accept <= 1'b1; // RULE_14
          irq_number <= irq_sel[2:0]; // RULE_14
          vector_address <= `VEC_RESET - {11'h000, irq_sel, 1'b0} - 16'h0002;
          vector_fetch <= 1'b1;
        end
        if (wait_instr) begin
          flg_r[3] <= 1'b0; // RULE_19
          pwr_r <= ST_WAIT;
          cpu_clk_en <= 1'b0; // RULE_19
        end else if (stop_instr) begin
          flg_r[3] <= 1'b0; // RULE_20
          pwr_r <= ST_STOP;
          cpu_clk_en <= 1'b0; // RULE_20
        end
      end else if (pwr_r == ST_WAIT) begin
        // Any request wakes; mask stays clear
        if (irq_sel != 4'h8) begin
          pwr_r <= ST_RUN; // RULE_19
          cpu_clk_en <= 1'b1;
        end
      end else if (pwr_r == ST_STOP) begin
        if (ext_s2_r) begin
          pwr_r <= ST_STAB;
          stab_r <= STAB_COUNT;
        end
      end else if (pwr_r == ST_STAB) begin
        // Clock held off until the oscillator settles
        if (stab_r <= 32'h00000001) begin
          pwr_r <= ST_RUN; // RULE_20
          cpu_clk_en <= 1'b1; // RULE_20
        end else begin
          stab_r <= stab_r - 32'h00000001;
        end
      end
      // Index pointer only moves by register writes here
      idx_r <= idx_r; // RULE_02
      // AXI write capture
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        // Bus writes override the sequencer in the same cycle
        case (aw_r)
          `OFS_ACC: if (ws_r[0]) acc_r <= wd_r[7:0];
          `OFS_IDX: idx_r <= merge16(idx_r, wd_r, ws_r); // RULE_02
          `OFS_SP: sp_r <= merge16(sp_r, wd_r, ws_r);
          `OFS_PC: pc_r <= merge16(pc_r, wd_r, ws_r);
          `OFS_FLAGS: if (ws_r[0]) flg_r <= {wd_r[7], wd_r[4:0]};
          `OFS_CTRL: if (ws_r[0]) ctrl_go_r <= wd_r[0];
          `OFS_STATUS, `OFS_VEC: s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // AXI read: one cycle after address
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> cpu_core_assertions.sv
// Port-level checks for the CPU register and flag core
`include "cpu_core_regs.vh"
module cpu_core_assertions #(
  parameter [31:0] STAB_COUNT = `STAB_CYCLES
) (
  // Clock and reset
  input logic core_clk,
  input logic rst,
  // Sequencer inputs
  input logic [15:0] sp_offset,
  input logic irq_stacked,
  input logic [7:0] irq_pending,
  input logic wait_instr,
  input logic stop_instr,
  input logic instr_last_cycle,
  input logic vector_load,
  // Core results
  input logic [15:0] stack_address,
  input logic irq_accept,
  input logic [2:0] irq_number,
  input logic [15:0] vector_address,
  input logic [7:0] instr_reg,
  input logic cpu_clk_en,
  input logic break_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic boot_r;
  logic stopped_r;
  logic [31:0] low_cnt_r;
  wire run = !boot_r && cpu_clk_en;
  // Boot and stop tracking; assumes the run enable keeps its reset value
  always @(posedge core_clk) begin
    if (rst) begin
      boot_r <= 1'b1;
      stopped_r <= 1'b0;
    end else begin
      if (vector_load)
        boot_r <= 1'b0;
      if (run && stop_instr)
        stopped_r <= 1'b1;
      else if (cpu_clk_en)
        stopped_r <= 1'b0;
    end
    low_cnt_r <= cpu_clk_en ? 32'h0 : low_cnt_r + 32'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Stop accepted, clock gated on the next edge
  sequence stop_entry;
    run && stop_instr ##1 !cpu_clk_en;
  endsequence
  a_boot_vector: assert property ($fell(rst) |-> vector_address == `VEC_RESET)
    else $error("boot vector address wrong");
  a_sp_reset: assert property ($fell(rst) |=> stack_address == `SP_RESET + $past(sp_offset))
    else $error("stack pointer not preset");
  a_irq_gate: assert property (irq_accept |-> $past(irq_stacked) && $past(irq_pending) != 8'h00)
    else $error("interrupt accepted without cause");
  a_irq_priority: assert property (irq_accept |->
    ($past(irq_pending) & (8'h01 << irq_number)) != 8'h00 &&
    ($past(irq_pending) & ((8'h01 << irq_number) - 8'h01)) == 8'h00)
    else $error("interrupt priority wrong");
  a_wait_stops: assert property (run && wait_instr |=> !cpu_clk_en)
    else $error("wait left clock running");
  a_stop_gates: assert property (stop_entry |=> !cpu_clk_en [*3])
    else $error("stop clock restarted early");
  a_stab_delay: assert property (stopped_r && $rose(cpu_clk_en) |-> low_cnt_r >= STAB_COUNT)
    else $error("stop exit before settle delay");
  a_break_boundary: assert property ($rose(break_active) |-> $past(instr_last_cycle))
    else $error("break began mid instruction");
  a_break_opcode: assert property ($rose(break_active) |-> instr_reg == `SWI_OPCODE)
    else $error("break opcode not loaded");
endmodule

bind cpu_core cpu_core_assertions #(.STAB_COUNT(STAB_COUNT)) chk (
  .core_clk, .rst, .sp_offset, .irq_stacked, .irq_pending, .wait_instr, .stop_instr,
  .instr_last_cycle, .vector_load, .stack_address, .irq_accept, .irq_number,
  .vector_address, .instr_reg, .cpu_clk_en, .break_active
);

// >>> mem_partner.sv
// Memory-side model that serves the reset vector word
`include "cpu_core_regs.vh"
module mem_partner #(
  parameter logic [15:0] BOOT_TARGET = 16'hC0DE
) (
  // Clock and reset
  input logic core_clk,
  input logic rst,
  // Fetch request and answer
  input logic vector_fetch,
  input logic [15:0] vector_address,
  input logic slow,
  output logic vector_load = 1'b0,
  output logic [15:0] vector_data = 16'h5A5A
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  logic answer;
  assign answer = !rst && !(vector_fetch && vector_address == `VEC_RESET) && wait_n == 1;
  // Answer after one or four cycles; between answers the data bus toggles, never stale
  always @(posedge core_clk) begin
    vector_load <= answer;
    vector_data <= answer ? BOOT_TARGET : ~vector_data;
    if (rst)
      wait_n <= 0;
    else if (vector_fetch && vector_address == `VEC_RESET)
      wait_n <= slow ? 4 : 1;
    else if (wait_n > 0)
      wait_n <= wait_n - 1;
  end
endmodule

// >>> tb_cpu_register_and_flag_core.sv
// Self-checking bench for the CPU register and flag core
`include "cpu_core_regs.vh"
module tb_cpu_register_and_flag_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BOOT_PC = 16'hC0DE; // Arbitrary boot target
  logic core_clk = 1'b0, rst = 1'b1, slow = 1'b1, ext_irq_pin = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, monitor_mode = 1'b0;
  logic instr_last_cycle = 1'b0, break_request = 1'b0, break_match = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, alu_operand = 8'h00;
  logic [7:0] irq_pending = 8'h00, flags_pulled = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd_data;
  logic [3:0] s_axi_wstrb = 4'hF, alu_op = 4'h0;
  logic [15:0] pc_target = 16'h0, sp_offset = 16'h0;
  logic [10:0] pls = 11'h000;
  logic [1:0] rd_resp, wr_resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire vector_load, irq_accept, vector_fetch, cpu_clk_en, break_active;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] vector_data, stack_address, vector_address;
  wire [2:0] irq_number;
  wire [7:0] instr_reg;
  int fails, n_compared, cyc, i, k, acc, flg, res, idx_v;
  cpu_core #(.STAB_COUNT(32'h4)) dut (.*, .pc_inc(pls[0]), .pc_load(pls[1]),
    .sp_push(pls[2]), .sp_pull(pls[3]), .reset_stack_instr(pls[4]),
    .clear_mask_instr(pls[5]), .set_mask_instr(pls[6]), .mask_restore(pls[7]),
    .irq_stacked(pls[8]), .wait_instr(pls[9]), .stop_instr(pls[10]));
  mem_partner #(.BOOT_TARGET(BOOT_PC)) mem (.*);
  initial forever #4 core_clk = ~core_clk;
  // Hang guard, far above the normal run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize;
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // One-cycle sequencer strobes; outputs sampled at the following low phase
  task automatic pulse(input logic [10:0] m);
    @(posedge core_clk);
    pls <= m;
    @(posedge core_clk);
    pls <= 11'h000;
    @(negedge core_clk);
  endtask
  task automatic do_reset(input logic s);
    @(posedge core_clk);
    rst <= 1'b1;
    slow <= s;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (k = 0; k < 40 && !vector_load; k++) @(posedge core_clk);
    rd(`OFS_SP);
    chk(rd_data, 32'h000000FF);
    rd(`OFS_FLAGS);
    chk(rd_data & 32'h68, 32'h68);
    rd(`OFS_PC);
    chk(rd_data, {16'h0, BOOT_PC});
    rd(`OFS_STATUS);
    chk(rd_data, 32'h04);
  endtask
  // Reference flag and accumulator behaviour
  function automatic void alu_model(input int op, input int m);
    int c, v, h, r;
    c = flg & 1;
    h = (flg >> 4) & 1;
    v = (flg >> 7) & 1;
    r = acc;
    case (op)
      1, 2: begin
        r = acc + m + (op == 2 ? c : 0);
        h = ((acc & 15) + (m & 15) + (op == 2 ? c : 0)) >> 4;
        c = r >> 8;
        v = (((acc ^ r) & (m ^ r)) >> 7) & 1;
      end
      3: begin
        r = acc - m;
        c = m > acc;
        v = (((acc ^ m) & (acc ^ r)) >> 7) & 1;
      end
      4, 5, 6, 7: begin
        r = op == 4 ? acc & m : op == 5 ? acc | m : op == 6 ? acc ^ m : m;
        v = 0;
      end
      8: r = acc << 1;
      9, 10: r = (acc >> 1) | (op == 10 ? c << 7 : 0);
      default: c = m & 1;
    endcase
    r = r & 255;
    if (op == 8) c = acc >> 7;
    if (op == 9 || op == 10) c = acc & 1;
    if (op >= 8 && op <= 10) v = (r >> 7) ^ c;
    if (op != 11) flg = (flg & 8'h08) | ((r >> 5) & 4) | (r == 0 ? 2 : 0);
    flg = (flg & 8'h0E) | 8'h60 | (v << 7) | (h << 4) | c;
    acc = r;
  endfunction
  initial begin
    res = $urandom(32'h8967445F);
    do_reset(1'b1);
    res = $urandom & 16'hFFFF;
    wr(`OFS_IDX, res);
    rd(`OFS_IDX);
    chk(rd_data, res);
    chk(wr_resp, 2'h0);
    idx_v = res;
    // Stack moves: push wins over pull, reset-stack wins over both
    wr(`OFS_SP, 32'h1234);
    for (i = 0; i < 3; i++) pulse(11'h004);
    pulse(11'h008);
    pulse(11'h00C);
    rd(`OFS_SP);
    chk(rd_data, 32'h1231);
    @(posedge core_clk) sp_offset <= res;
    pulse(11'h000);
    chk(stack_address, 16'(16'h1231 + res[15:0]));
    pulse(11'h01C);
    rd(`OFS_SP);
    chk(rd_data, 32'h12FF);
    wr(`OFS_PC, 32'h1234);
    pulse(11'h001);
    rd(`OFS_PC);
    chk(rd_data, 32'h1235);
    @(posedge core_clk) pc_target <= res;
    pulse(11'h003);
    rd(`OFS_PC);
    chk(rd_data, res);
    // Run enable off: sequencer strobes are ignored
    wr(`OFS_CTRL, 32'h0);
    pulse(11'h001);
    rd(`OFS_PC);
    chk(rd_data, res);
    wr(`OFS_CTRL, 32'h1);
    for (i = 0; i < 33; i++) begin
      acc = $urandom & 255;
      flg = ($urandom & 8'h97) | 8'h68;
      res = $urandom & 255;
      wr(`OFS_ACC, acc);
      wr(`OFS_FLAGS, flg);
      @(posedge core_clk);
      alu_op <= 1 + i % 11;
      alu_operand <= res;
      @(posedge core_clk);
      alu_op <= 4'h0;
      alu_model(1 + i % 11, res);
      rd(`OFS_ACC);
      chk(rd_data, acc);
      rd(`OFS_FLAGS);
      chk(rd_data, flg);
    end
    // Masked request ignored, then lowest pending index served
    @(posedge core_clk) irq_pending <= 8'h68;
    pulse(11'h100);
    chk(irq_accept, 1'b0);
    pulse(11'h020);
    pulse(11'h100);
    chk(irq_accept, 1'b1);
    chk(irq_number, 3'h3);
    chk(vector_address, 16'hFFF6);
    @(posedge core_clk) irq_pending <= 8'h00;
    rd(`OFS_FLAGS);
    chk(rd_data & 32'h08, 32'h08);
    rd(`OFS_IDX);
    chk(rd_data, idx_v);
    @(posedge core_clk) flags_pulled <= 8'h81;
    pulse(11'h080);
    rd(`OFS_FLAGS);
    chk(rd_data, 32'hE1);
    pulse(11'h040);
    pulse(11'h200);
    chk(cpu_clk_en, 1'b0);
    @(posedge core_clk) irq_pending <= 8'h02;
    for (k = 0; k < 20 && !cpu_clk_en; k++) @(posedge core_clk);
    irq_pending <= 8'h00;
    rd(`OFS_FLAGS);
    chk(rd_data & 32'h08, 32'h0);
    pulse(11'h040);
    pulse(11'h400);
    chk(cpu_clk_en, 1'b0);
    @(posedge core_clk) ext_irq_pin <= 1'b1;
    for (k = 0; k < 60 && !cpu_clk_en; k++) @(posedge core_clk);
    ext_irq_pin <= 1'b0;
    chk(k >= 4 && cpu_clk_en, 1'b1);
    rd(`OFS_FLAGS);
    chk(rd_data & 32'h08, 32'h0);
    // Break held off until the last cycle, then ended only once released
    for (i = 0; i < 2; i++) begin
      @(posedge core_clk);
      monitor_mode <= i;
      break_request <= 1'b1;
      break_match <= 1'b1;
      pulse(11'h000);
      chk(break_active, 1'b0);
      @(posedge core_clk) instr_last_cycle <= 1'b1;
      for (k = 0; k < 10 && !break_active; k++) @(posedge core_clk);
      instr_last_cycle <= 1'b0;
      break_match <= 1'b0;
      @(negedge core_clk);
      chk(instr_reg, `SWI_OPCODE);
      chk(vector_address, i ? `VEC_BREAK_MON : `VEC_BREAK);
      rd(`OFS_VEC);
      chk(rd_data, `SWI_OPCODE);
      pulse(11'h080);
      chk(break_active, 1'b1);
      @(posedge core_clk) break_request <= 1'b0;
      pulse(11'h080);
      chk(break_active, 1'b0);
    end
    rd(8'h20);
    chk(rd_resp, 2'h2);
    chk(rd_data, 32'h0);
    wr(8'h20, 32'h0);
    chk(wr_resp, 2'h2);
    do_reset(1'b0);
    summarize();
  end
endmodule
